/* include/cfg_pkg.sv */
// Purpose: Shared constants for the primary configuration register bank and its host.
// Assumes: 32-bit register words, one clock domain.
// Notes: Offsets are word addresses of the control command space.
package cfg_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] PRIMARY_CFG_OFS = 8'h04;
    localparam logic [7:0] DEV_STATUS_OFS = 8'h08;
    localparam logic [31:0] PRIMARY_CFG_RESET = 32'h0000_0006;
    localparam logic [31:0] DEV_STATUS_RESET = 32'h0000_0001;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int SYNC_BIT = 15;
    localparam int FCS_CHECK_BIT = 14;
    localparam int SEL_ALIGN_BIT = 13;
    localparam int ZERO_ALIGN_BIT = 12;
    localparam int THRESH_LSB = 10;
    localparam int TX_CUT_BIT = 9;
    localparam int RX_CUT_BIT = 8;
    localparam int TSTAMP_BIT = 7;
    localparam int CPS_LSB = 0;
    localparam int RESET_DONE_BIT = 0;

    // ****************************************************************
    // Field values
    // ****************************************************************
    localparam logic [2:0] CPS_MIN = 3'h3;
    localparam logic [2:0] CPS_MAX = 3'h6;
    localparam logic [2:0] CPS_RESET = PRIMARY_CFG_RESET[2:0];
    localparam int CREDIT_W = 6;

    // Free credits needed before the credit interrupt may fire.
    function automatic logic [CREDIT_W-1:0] credits_needed(input logic [1:0] sel);
        logic [CREDIT_W-1:0] n;
        n = 6'h01;
        case (sel)
            2'h0: n = 6'h01;
            2'h1: n = 6'h04;
            2'h2: n = 6'h08;
            2'h3: n = 6'h10;
            default: n = 6'h01;
        endcase
        return n;
    endfunction : credits_needed

endpackage : cfg_pkg

/* include/cfg_link_if.sv */
// Purpose: Control command and footer link between host and device.
// Assumes: Both ends on clk_i; one request outstanding at a time.
// Notes: No clocking block; the bench connects both modports.
interface cfg_link_if;
    logic req_valid;
    logic req_write;
    logic [7:0] req_addr;
    logic [31:0] req_wdata;
    logic rsp_valid;
    logic [31:0] rsp_rdata;
    logic interrupt_out_n;
    logic footer_valid;
    logic footer_sync;

    modport device (
        input req_valid, req_write, req_addr, req_wdata,
        output rsp_valid, rsp_rdata, interrupt_out_n, footer_valid, footer_sync
    );
    modport host (
        output req_valid, req_write, req_addr, req_wdata,
        input rsp_valid, rsp_rdata, interrupt_out_n, footer_valid, footer_sync
    );
endinterface : cfg_link_if

/* logic/credit_threshold_check.sv */
// Purpose: Registered compare of free transmit credits against the chosen threshold.
// Assumes: Credit count is synchronous to clk_i.
// Notes: Result lags the inputs by one clock.
module credit_threshold_check
    import cfg_pkg::*;
#(
    parameter int CW = CREDIT_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] tx_credit_irq_threshold_i,
    input wire logic [CW-1:0] tx_free_credits_i,
    output logic met_o
);
    logic met_q;
    logic met_d;

    always_comb begin
        met_d = tx_free_credits_i >= CW'(credits_needed(tx_credit_irq_threshold_i));
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            met_q <= 1'b0;
        end else begin
            met_q <= met_d;
        end
    end

    assign met_o = met_q;
endmodule : credit_threshold_check

/* logic/cfg_device.sv */
// Purpose: Device end holding the primary configuration register and reset status.
// Assumes: Host keeps one control command outstanding at a time.
// Notes: Every user-side output comes from the registered state struct.
module cfg_device
    import cfg_pkg::*;
#(
    parameter int CW = CREDIT_W,
    parameter int WOFS_W = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    cfg_link_if.device link,
    input wire logic [CW-1:0] tx_free_credits_i,
    input wire logic footer_req_i,
    input wire logic rx_first_chunk_i,
    input wire logic rx_payload_start_i,
    input wire logic [WOFS_W-1:0] rx_word_offset_i,
    output logic configured_o,
    output logic tx_fcs_check_enable_o,
    output logic tx_cut_through_enable_o,
    output logic rx_cut_through_enable_o,
    output logic tx_store_full_frame_o,
    output logic rx_store_full_frame_o,
    output logic frame_timestamp_enable_o,
    output logic [6:0] chunk_payload_bytes_o,
    output logic rx_start_allowed_o,
    output logic [WOFS_W-1:0] start_word_offset_o,
    output logic reset_complete_flag_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic sync;
        logic fcs_check;
        logic sel_align;
        logic zero_align;
        logic [1:0] thresh;
        logic tx_cut;
        logic rx_cut;
        logic tstamp;
        logic [2:0] chunk_payload_selector;
        logic reset_done;
        logic rsp_valid;
        logic [31:0] rsp_rdata;
        logic irq_n;
        logic footer_valid;
        logic footer_sync;
        logic start_ok;
        logic [WOFS_W-1:0] start_wofs;
        logic [6:0] chunk_bytes;
    } dev_state_s;

    dev_state_s st_q;
    dev_state_s st_d;
    logic credit_met;
    logic wr_cfg;
    logic wr_status;
    logic rd_req;

    credit_threshold_check #(
        .CW(CW)
    ) credit_threshold_check_inst (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .tx_credit_irq_threshold_i(st_q.thresh),
        .tx_free_credits_i(tx_free_credits_i),
        .met_o(credit_met)
    );

    // Reading the register back: reserved and unmodelled fields are zero.
    function automatic logic [31:0] cfg_word(input dev_state_s s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SYNC_BIT] = s.sync;
        w[FCS_CHECK_BIT] = s.fcs_check;
        w[SEL_ALIGN_BIT] = s.sel_align;
        w[ZERO_ALIGN_BIT] = s.zero_align;
        w[THRESH_LSB +: 2] = s.thresh;
        w[TX_CUT_BIT] = s.tx_cut;
        w[RX_CUT_BIT] = s.rx_cut;
        w[TSTAMP_BIT] = s.tstamp;
        w[CPS_LSB +: 3] = s.chunk_payload_selector;
        return w;
    endfunction : cfg_word

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        wr_cfg = link.req_valid && link.req_write && (link.req_addr == PRIMARY_CFG_OFS);
        wr_status = link.req_valid && link.req_write && (link.req_addr == DEV_STATUS_OFS);
        rd_req = link.req_valid && !link.req_write;

        if (wr_cfg) begin
            // Writing zero never clears the flag; only reset does.
            st_d.sync = st_q.sync | link.req_wdata[SYNC_BIT];
            st_d.fcs_check = link.req_wdata[FCS_CHECK_BIT];
            st_d.sel_align = link.req_wdata[SEL_ALIGN_BIT];
            st_d.zero_align = link.req_wdata[ZERO_ALIGN_BIT];
            st_d.thresh = link.req_wdata[THRESH_LSB +: 2];
            st_d.tx_cut = link.req_wdata[TX_CUT_BIT];
            st_d.rx_cut = link.req_wdata[RX_CUT_BIT];
            st_d.tstamp = link.req_wdata[TSTAMP_BIT];
            // Out-of-range sizes are ignored so the chunk size stays legal.
            if (!st_q.sync && link.req_wdata[CPS_LSB +: 3] >= CPS_MIN
                    && link.req_wdata[CPS_LSB +: 3] <= CPS_MAX) begin
                st_d.chunk_payload_selector = link.req_wdata[CPS_LSB +: 3];
            end
        end

        // Status is write one to clear; nothing sets it outside reset.
        if (wr_status && link.req_wdata[RESET_DONE_BIT]) begin
            st_d.reset_done = 1'b0;
        end

        // Every request, read or write, gets one answer pulse.
        st_d.rsp_valid = link.req_valid;
        st_d.rsp_rdata = 32'h0000_0000;
        if (rd_req) begin
            case (link.req_addr)
                PRIMARY_CFG_OFS: st_d.rsp_rdata = cfg_word(st_q);
                DEV_STATUS_OFS: st_d.rsp_rdata = {31'h0000_0000, st_q.reset_done};
                default: st_d.rsp_rdata = 32'h0000_0000;
            endcase
        end

        // Interrupt stays low while reset is unacknowledged or credits suffice.
        st_d.irq_n = !(st_d.reset_done || credit_met);

        st_d.footer_valid = footer_req_i;
        st_d.footer_sync = st_q.sync;

        // Alignment options decide where a received frame may begin.
        if (st_q.sel_align) begin
            st_d.start_ok = rx_first_chunk_i && rx_payload_start_i;
        end else if (st_q.zero_align) begin
            st_d.start_ok = rx_payload_start_i;
        end else begin
            st_d.start_ok = 1'b1;
        end
        if (st_q.sel_align || st_q.zero_align) begin
            st_d.start_wofs = '0;
        end else begin
            st_d.start_wofs = rx_word_offset_i;
        end

        st_d.chunk_bytes = 7'(8'h01 << st_d.chunk_payload_selector);
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q.sync <= PRIMARY_CFG_RESET[SYNC_BIT];
            st_q.fcs_check <= PRIMARY_CFG_RESET[FCS_CHECK_BIT];
            st_q.sel_align <= PRIMARY_CFG_RESET[SEL_ALIGN_BIT];
            st_q.zero_align <= PRIMARY_CFG_RESET[ZERO_ALIGN_BIT];
            st_q.thresh <= PRIMARY_CFG_RESET[THRESH_LSB +: 2];
            st_q.tx_cut <= PRIMARY_CFG_RESET[TX_CUT_BIT];
            st_q.rx_cut <= PRIMARY_CFG_RESET[RX_CUT_BIT];
            st_q.tstamp <= PRIMARY_CFG_RESET[TSTAMP_BIT];
            st_q.chunk_payload_selector <= CPS_RESET;
            st_q.reset_done <= DEV_STATUS_RESET[RESET_DONE_BIT];
            st_q.rsp_valid <= 1'b0;
            st_q.rsp_rdata <= 32'h0000_0000;
            st_q.irq_n <= 1'b0;
            st_q.footer_valid <= 1'b0;
            st_q.footer_sync <= 1'b0;
            st_q.start_ok <= 1'b1;
            st_q.start_wofs <= '0;
            st_q.chunk_bytes <= 7'(8'h01 << CPS_RESET);
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.rsp_valid = st_q.rsp_valid;
    assign link.rsp_rdata = st_q.rsp_rdata;
    assign link.interrupt_out_n = st_q.irq_n;
    assign link.footer_valid = st_q.footer_valid;
    assign link.footer_sync = st_q.footer_sync;

    assign configured_o = st_q.sync;
    assign tx_fcs_check_enable_o = st_q.fcs_check;
    assign tx_cut_through_enable_o = st_q.tx_cut;
    assign rx_cut_through_enable_o = st_q.rx_cut;
    assign tx_store_full_frame_o = !st_q.tx_cut;
    assign rx_store_full_frame_o = !st_q.rx_cut;
    assign frame_timestamp_enable_o = st_q.tstamp;
    assign chunk_payload_bytes_o = st_q.chunk_bytes;
    assign rx_start_allowed_o = st_q.start_ok;
    assign start_word_offset_o = st_q.start_wofs;
    assign reset_complete_flag_o = st_q.reset_done;

endmodule : cfg_device

/* logic/cfg_host.sv */
// Purpose: Host end issuing control commands and guarding unsafe configuration writes.
// Assumes: User side issues one command and waits for its answer or refusal.
// Notes: A refused write never reaches the link.
module cfg_host
    import cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    cfg_link_if.host link,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_addr_i,
    input wire logic [31:0] cmd_wdata_i,
    input wire logic mac_crc_append_i,
    input wire logic fast_feed_i,
    input wire logic rx_enabled_i,
    input wire logic generic_spi_mode_i,
    output logic cmd_ready_o,
    output logic cmd_error_o,
    output logic rd_valid_o,
    output logic [31:0] rd_data_o,
    output logic irq_o,
    output logic footer_valid_o,
    output logic footer_sync_o
);

    typedef enum logic {
        HS_IDLE = 1'b0,
        HS_WAIT = 1'b1
    } host_state_e;

    typedef struct packed {
        host_state_e fsm;
        logic req_valid;
        logic req_write;
        logic [7:0] req_addr;
        logic [31:0] req_wdata;
        logic ready;
        logic error;
        logic rd_valid;
        logic [31:0] rd_data;
        logic irq;
        logic footer_valid;
        logic footer_sync;
    } host_state_s;

    host_state_s st_q;
    host_state_s st_d;
    logic refuse;

    always_comb begin
        st_d = st_q;
        st_d.req_valid = 1'b0;
        st_d.error = 1'b0;
        st_d.rd_valid = 1'b0;
        refuse = cmd_write_i && (cmd_addr_i == PRIMARY_CFG_OFS) && (
            (cmd_wdata_i[FCS_CHECK_BIT] && mac_crc_append_i) ||
            (cmd_wdata_i[TX_CUT_BIT] && !fast_feed_i) ||
            (cmd_wdata_i[RX_CUT_BIT] && rx_enabled_i) ||
            (cmd_wdata_i[RX_CUT_BIT] && generic_spi_mode_i));
        case (st_q.fsm)
            HS_IDLE: begin
                if (cmd_valid_i) begin
                    if (refuse) begin
                        st_d.error = 1'b1;
                    end else begin
                        st_d.req_valid = 1'b1;
                        st_d.req_write = cmd_write_i;
                        st_d.req_addr = cmd_addr_i;
                        st_d.req_wdata = cmd_wdata_i;
                        st_d.fsm = HS_WAIT;
                    end
                end
            end
            HS_WAIT: begin
                if (link.rsp_valid) begin
                    st_d.rd_valid = 1'b1;
                    st_d.rd_data = link.rsp_rdata;
                    st_d.fsm = HS_IDLE;
                end
            end
            default: st_d.fsm = HS_IDLE;
        endcase
        st_d.ready = (st_d.fsm == HS_IDLE);
        st_d.irq = !link.interrupt_out_n;
        st_d.footer_valid = link.footer_valid;
        if (link.footer_valid) begin
            st_d.footer_sync = link.footer_sync;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '{fsm: HS_IDLE, ready: 1'b1, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign link.req_valid = st_q.req_valid;
    assign link.req_write = st_q.req_write;
    assign link.req_addr = st_q.req_addr;
    assign link.req_wdata = st_q.req_wdata;
    assign cmd_ready_o = st_q.ready;
    assign cmd_error_o = st_q.error;
    assign rd_valid_o = st_q.rd_valid;
    assign rd_data_o = st_q.rd_data;
    assign irq_o = st_q.irq;
    assign footer_valid_o = st_q.footer_valid;
    assign footer_sync_o = st_q.footer_sync;

endmodule : cfg_host

/* verif/cfg_link_monitor.sv */
// Purpose: Concurrent checks on the host to device configuration link.
// Assumes: One clock domain; the host keeps one command outstanding.
// Notes: Config-done is shadowed here so that reads and footers can be judged.
module cfg_link_monitor
    import cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [7:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_rdata,
    input wire logic interrupt_out_n,
    input wire logic footer_valid,
    input wire logic footer_sync
);
    // ****************************************************************
    // Shadow of config-done
    // ****************************************************************
    logic sync_q;
    logic set_sync;
    assign set_sync = req_valid && req_write && req_addr == PRIMARY_CFG_OFS;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_q <= 1'b0;
        end else if (set_sync && req_wdata[SYNC_BIT]) begin
            sync_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence cfg_rd_s;
        req_valid && !req_write && req_addr == PRIMARY_CFG_OFS;
    endsequence
    sequence wr_s;
        req_valid && req_write;
    endsequence
    sequence odd_rd_s;
        req_valid && !req_write && req_addr != PRIMARY_CFG_OFS && req_addr != DEV_STATUS_OFS;
    endsequence
    property sync_rd_p;
        cfg_rd_s |=> rsp_rdata[SYNC_BIT] == $past(sync_q);
    endproperty
    property reserved_rd_p;
        cfg_rd_s |=> rsp_rdata[31:16] == 16'h0000 && rsp_rdata[6:3] == 4'h0;
    endproperty
    property cps_rd_p;
        cfg_rd_s |=> rsp_rdata[2:0] >= CPS_MIN && rsp_rdata[2:0] <= CPS_MAX;
    endproperty

    a_rsp_after_req: assert property (req_valid |=> rsp_valid)
        else $error("No response one cycle after a request.");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("Response without a request.");
    a_idle_rdata_zero: assert property (!rsp_valid |-> rsp_rdata == 32'h0000_0000)
        else $error("Read data not zero outside a response.");
    a_write_rsp_zero: assert property (wr_s |=> rsp_rdata == 32'h0000_0000)
        else $error("Write response carries data.");
    a_reserved_bits_zero: assert property (reserved_rd_p)
        else $error("Reserved bits read as nonzero.");
    a_unmapped_zero: assert property (odd_rd_s |=> rsp_rdata == 32'h0000_0000)
        else $error("Unmapped read returned data.");
    a_sync_readback: assert property (sync_rd_p)
        else $error("Config-done read back wrong.");
    a_cps_legal: assert property (cps_rd_p)
        else $error("Payload selector out of range.");
    a_footer_sync: assert property (footer_valid |-> footer_sync == $past(sync_q))
        else $error("Footer config-done differs from register.");
    a_irq_after_reset: assert property ($rose(rstn_i) |-> !interrupt_out_n)
        else $error("Interrupt not asserted after reset.");
endmodule : cfg_link_monitor

/* verif/macphy_primary_config_register_test.sv */
// Purpose: Self-checking bench joining the host and device ends of the config link.
// Assumes: 10 MHz clock; both ends share one reset.
// Notes: Host guards stay permissive except where a refusal is wanted.
module macphy_primary_config_register_test import cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic clk_i, rstn_i, cmd_valid_i, cmd_write_i, mac_crc_append_i, fast_feed_i;
    logic rx_enabled_i, generic_spi_mode_i, footer_req_i, rx_first_chunk_i, rx_payload_start_i;
    logic [7:0] cmd_addr_i;
    logic [31:0] cmd_wdata_i, rd_data_o;
    logic [5:0] tx_free_credits_i;
    logic [3:0] rx_word_offset_i, start_word_offset_o;
    logic cmd_ready_o, cmd_error_o, rd_valid_o, irq_o, footer_valid_o, footer_sync_o;
    logic configured_o, tx_fcs_check_enable_o, tx_cut_through_enable_o, rx_cut_through_enable_o;
    logic tx_store_full_frame_o, rx_store_full_frame_o, frame_timestamp_enable_o;
    logic rx_start_allowed_o, reset_complete_flag_o;
    logic [6:0] chunk_payload_bytes_o;
    int fail_count = 0;
    int cmp_count = 0;

    cfg_link_if link();
    cfg_device cfg_device_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link.device),
        .tx_free_credits_i(tx_free_credits_i), .footer_req_i(footer_req_i),
        .rx_first_chunk_i(rx_first_chunk_i), .rx_payload_start_i(rx_payload_start_i),
        .rx_word_offset_i(rx_word_offset_i), .configured_o(configured_o),
        .tx_fcs_check_enable_o(tx_fcs_check_enable_o),
        .tx_cut_through_enable_o(tx_cut_through_enable_o),
        .rx_cut_through_enable_o(rx_cut_through_enable_o),
        .tx_store_full_frame_o(tx_store_full_frame_o),
        .rx_store_full_frame_o(rx_store_full_frame_o),
        .frame_timestamp_enable_o(frame_timestamp_enable_o),
        .chunk_payload_bytes_o(chunk_payload_bytes_o), .rx_start_allowed_o(rx_start_allowed_o),
        .start_word_offset_o(start_word_offset_o), .reset_complete_flag_o(reset_complete_flag_o));
    cfg_host cfg_host_inst (.clk_i(clk_i), .rstn_i(rstn_i), .link(link.host),
        .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
        .cmd_wdata_i(cmd_wdata_i), .mac_crc_append_i(mac_crc_append_i), .fast_feed_i(fast_feed_i),
        .rx_enabled_i(rx_enabled_i), .generic_spi_mode_i(generic_spi_mode_i),
        .cmd_ready_o(cmd_ready_o), .cmd_error_o(cmd_error_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .irq_o(irq_o), .footer_valid_o(footer_valid_o),
        .footer_sync_o(footer_sync_o));
    cfg_link_monitor cfg_link_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .req_valid(link.req_valid), .req_write(link.req_write), .req_addr(link.req_addr),
        .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid), .rsp_rdata(link.rsp_rdata),
        .interrupt_out_n(link.interrupt_out_n), .footer_valid(link.footer_valid),
        .footer_sync(link.footer_sync));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // The answer is polled under a bound so a lost response cannot hang the run.
    task automatic cmd(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_write_i <= w;
        cmd_addr_i <= a;
        cmd_wdata_i <= d;
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        #1;
        while (rd_valid_o !== 1'b1 && cmd_error_o !== 1'b1 && n < 10) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk({n < 10, cmd_ready_o}, 2'h3);
        r = rd_data_o;
        e = cmd_error_o;
    endtask : cmd

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        cmd(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] r;
        logic e;
        cmd(1'b1, a, d, r, e);
        chk(e, exp_err);
    endtask : wr

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        settle(2);
        chk({irq_o, configured_o, reset_complete_flag_o}, 3'h5);
        chk(chunk_payload_bytes_o, 7'h40);
        rd(PRIMARY_CFG_OFS, PRIMARY_CFG_RESET);
        rd(DEV_STATUS_OFS, 32'h0000_0001);
        rd(8'h10, 32'h0000_0000);
    endtask : t_reset

    task automatic t_footer(input logic exp);
        int n = 0;
        @(posedge clk_i);
        footer_req_i <= 1'b1;
        @(posedge clk_i);
        footer_req_i <= 1'b0;
        #1;
        while (footer_valid_o !== 1'b1 && n < 5) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk({footer_valid_o, footer_sync_o}, {1'b1, exp});
    endtask : t_footer

    task automatic t_fields();
        logic [5:0] en;
        wr(PRIMARY_CFG_OFS, 32'hFFFF_7FFC, 1'b0);
        rd(PRIMARY_CFG_OFS, 32'h0000_7F84);
        en = {tx_fcs_check_enable_o, tx_cut_through_enable_o, rx_cut_through_enable_o,
            tx_store_full_frame_o, rx_store_full_frame_o, frame_timestamp_enable_o};
        chk(en, 6'h39);
        chk(chunk_payload_bytes_o, 7'h10);
        wr(PRIMARY_CFG_OFS, 32'h0000_0003, 1'b0);
        en = {tx_fcs_check_enable_o, tx_cut_through_enable_o, rx_cut_through_enable_o,
            tx_store_full_frame_o, rx_store_full_frame_o, frame_timestamp_enable_o};
        chk(en, 6'h06);
        wr(PRIMARY_CFG_OFS, 32'h0000_0007, 1'b0);
        rd(PRIMARY_CFG_OFS, 32'h0000_0003);
        chk(chunk_payload_bytes_o, 7'h08);
    endtask : t_fields

    task automatic t_refuse();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            mac_crc_append_i <= (i == 0);
            fast_feed_i <= (i != 1);
            rx_enabled_i <= (i == 2);
            generic_spi_mode_i <= (i == 3);
            wr(PRIMARY_CFG_OFS, i == 0 ? 32'h0000_4006 : i == 1 ? 32'h0000_0206 : 32'h0000_0106,
                1'b1);
            rd(PRIMARY_CFG_OFS, 32'h0000_0003);
        end
        @(posedge clk_i);
        {mac_crc_append_i, fast_feed_i, rx_enabled_i, generic_spi_mode_i} <= 4'h4;
    endtask : t_refuse

    task automatic t_align();
        logic ok;
        logic [4:0] exp;
        for (int m = 0; m < 3; m++) begin
            wr(PRIMARY_CFG_OFS, {18'h0_0000, m == 0, m == 1, 12'h003}, 1'b0);
            for (int c = 0; c < 4; c++) begin
                @(posedge clk_i);
                {rx_first_chunk_i, rx_payload_start_i} <= 2'(c);
                rx_word_offset_i <= 4'h5;
                settle(2);
                ok = m == 0 ? c == 3 : m == 1 ? c[0] : 1'b1;
                exp = {ok, m < 2 ? 4'h0 : 4'h5};
                chk({rx_start_allowed_o, start_word_offset_o}, exp);
            end
        end
    endtask : t_align

    task automatic t_credit();
        int need;
        wr(DEV_STATUS_OFS, 32'h0000_0001, 1'b0);
        rd(DEV_STATUS_OFS, 32'h0000_0000);
        for (int s = 0; s < 4; s++) begin
            need = s == 0 ? 1 : 4 << (s - 1);
            wr(PRIMARY_CFG_OFS, {20'h0_0000, 2'(s), 10'h003}, 1'b0);
            @(posedge clk_i);
            tx_free_credits_i <= 6'(need - 1);
            settle(4);
            chk(irq_o, 1'b0);
            @(posedge clk_i);
            tx_free_credits_i <= 6'(need);
            settle(4);
            chk(irq_o, 1'b1);
        end
        @(posedge clk_i);
        tx_free_credits_i <= 6'h00;
    endtask : t_credit

    task automatic t_sync();
        wr(PRIMARY_CFG_OFS, 32'h0000_8005, 1'b0);
        rd(PRIMARY_CFG_OFS, 32'h0000_8005);
        chk({configured_o, chunk_payload_bytes_o}, {1'b1, 7'h20});
        wr(PRIMARY_CFG_OFS, 32'h0000_0006, 1'b0);
        rd(PRIMARY_CFG_OFS, 32'h0000_8005);
        chk({configured_o, chunk_payload_bytes_o}, {1'b1, 7'h20});
    endtask : t_sync

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    // ****************************************************************
    // Clock, sequence and watchdog
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    initial begin
        {rstn_i, cmd_valid_i, cmd_write_i, cmd_addr_i, cmd_wdata_i} = '0;
        {mac_crc_append_i, fast_feed_i, rx_enabled_i, generic_spi_mode_i} = 4'h4;
        {tx_free_credits_i, footer_req_i, rx_first_chunk_i, rx_payload_start_i} = '0;
        rx_word_offset_i = 4'h0;
        t_reset();
        t_footer(1'b0);
        t_fields();
        t_refuse();
        t_align();
        t_credit();
        t_sync();
        t_footer(1'b1);
        t_reset();
        results();
    end

    // The run needs under a thousand cycles; twenty thousand leaves ample margin.
    initial begin
        #2_000_000;
        fail_count++;
        results();
    end
endmodule : macphy_primary_config_register_test
